// ==== logic/aer_top.sv ====
/*
  alarm and event reporter: interval event flags, far-end completeness, alarm messages and notifications.
  assumes apb master on clk_in, event inputs on pins, a one-second tick pin and a 15-minute boundary pin.
*/
`timescale 1ns/100ps
`include "aer_params.svh"
module aer_top (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [4:0]  event_in,
  input  wire logic        sec_tick_in,
  input  wire logic        far_sec_ok_in,
  input  wire logic        interval_end_in,
  input  wire logic [6:0]  alarm_cond_in,
  input  wire logic        standalone_in,
  input  wire logic        auth_fail_in,
  input  wire logic        vendor_event_in,
  input  wire logic [7:0]  vendor_code_in,
  input  wire logic [3:0]  link_state_in,
  output logic             msg_valid_out,
  output aer_pkg::aer_msg_t msg_type_out,
  output logic      [7:0]  msg_code_out,
  output logic      [15:0] msg_cust_id_out,
  output logic             route_modem_out,
  output logic             route_com_out,
  output logic             route_dial_out,
  output logic             irq_out
);
  // ****************************************
  // input synchronisers
  // ****************************************
  localparam int NS = 30;
  logic [NS-1:0] s1_reg;
  logic [NS-1:0] s2_reg;
  logic [NS-1:0] s3_reg;
  logic [NS-1:0] stab_reg;
  logic [NS-1:0] raw_in;
  // the vendor code rides with its strobe so both settle in the same cycle
  assign raw_in = {vendor_code_in, standalone_in, alarm_cond_in, link_state_in,
                   auth_fail_in, vendor_event_in, interval_end_in, far_sec_ok_in,
                   sec_tick_in, event_in};
  // change is accepted only once stage two and three agree, filtering one-cycle glitches
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      stab_reg <= '0;
    end else begin
      s1_reg   <= raw_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      stab_reg <= (s2_reg & s3_reg) | (stab_reg & (s2_reg | s3_reg));
    end
  end
  logic [NS-1:0] prev_reg;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= stab_reg;
    end
  end
  wire [NS-1:0] rise = stab_reg & ~prev_reg;
  wire [NS-1:0] fall = ~stab_reg & prev_reg;
  wire [4:0] ev_lvl     = stab_reg[4:0];
  wire       tick_p     = rise[5];
  wire       far_ok     = stab_reg[6];
  wire       bound_p    = rise[7];
  wire       vendor_p   = rise[8];
  wire       auth_p     = rise[9];
  wire [3:0] link_up_p  = rise[13:10];
  wire [3:0] link_dn_p  = fall[13:10];
  wire [6:0] alarm_lvl  = stab_reg[20:14];
  wire       alone_lvl  = stab_reg[21];
  wire [7:0] vcode_lvl  = stab_reg[29:22];

  // ****************************************
  // apb slave and registers
  // ****************************************
  logic [31:0] ctrl_reg;
  logic [15:0] cust_id_reg;
  logic [3:0]  irq_stat_reg;
  logic [3:0]  irq_mask_reg;
  wire acc       = psel_in & penable_in;
  wire wr_acc    = acc & pwrite_in;
  wire hit_ctrl  = paddr_in == `AER_OFF_CTRL;
  wire hit_cust  = paddr_in == `AER_OFF_CUST_ID;
  wire hit_istat = paddr_in == `AER_OFF_IRQ_STAT;
  wire hit_imask = paddr_in == `AER_OFF_IRQ_MASK;
  wire mapped    = hit_ctrl | hit_cust | hit_istat | hit_imask | (paddr_in == `AER_OFF_EVENTS)
                   | (paddr_in == `AER_OFF_HIST) | (paddr_in == `AER_OFF_ALARM)
                   | (paddr_in == `AER_OFF_NOTIFY);
  wire wr_ctrl   = wr_acc & hit_ctrl;
  wire wr_cust   = wr_acc & hit_cust;
  wire wr_imask  = wr_acc & hit_imask;
  wire clear_perf_command = wr_ctrl & pwdata_in[`AER_CTRL_CLEAR];
  // the clear bit is a strobe, so it never stays set in the control word
  wire [31:0] ctrl_next = pwdata_in & ~(32'h1 << `AER_CTRL_CLEAR);
  assign pready_out  = 1'b1;
  assign pslverr_out = acc & ~mapped;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= `AER_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cust_id_reg <= `AER_CUST_ID_RESET;
    end else if (wr_cust) begin
      cust_id_reg <= pwdata_in[15:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_mask_reg <= 4'h0;
    end else if (wr_imask) begin
      irq_mask_reg <= pwdata_in[3:0];
    end
  end
  wire       master_notify_enable = ctrl_reg[`AER_CTRL_MASTER];
  wire       gen_en    = ctrl_reg[`AER_CTRL_GEN];
  wire       vendor_en = ctrl_reg[`AER_CTRL_VENDOR];
  wire       link_en   = ctrl_reg[`AER_CTRL_LINK];
  wire [3:0] if_sel    = ctrl_reg[`AER_CTRL_IF_LSB +: `AER_NUM_IF];

  // ****************************************
  // interval flags
  // ****************************************
  logic [4:0] work_ev_reg;
  logic [4:0] interval_event_flags;
  logic [9:0] sec_cnt_reg;
  logic       miss_reg;
  logic       far_end_interval_full;
  // the count stops at a full interval instead of wrapping
  wire        sec_full = sec_cnt_reg == `AER_SECONDS_PER_INT;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      work_ev_reg           <= 5'h00;
      interval_event_flags  <= 5'h00;
      sec_cnt_reg           <= 10'h000;
      miss_reg              <= 1'b0;
      far_end_interval_full <= 1'b0;
    end else if (clear_perf_command) begin
      work_ev_reg           <= 5'h00;
      interval_event_flags  <= 5'h00;
      sec_cnt_reg           <= 10'h000;
      miss_reg              <= 1'b0;
      far_end_interval_full <= 1'b0;
    end else if (bound_p) begin
      interval_event_flags  <= work_ev_reg | ev_lvl;
      far_end_interval_full <= ~miss_reg & sec_full;
      work_ev_reg           <= 5'h00;
      sec_cnt_reg           <= 10'h000;
      miss_reg              <= 1'b0;
    end else begin
      work_ev_reg <= work_ev_reg | ev_lvl;
      if (tick_p) begin
        sec_cnt_reg <= sec_full ? sec_cnt_reg : sec_cnt_reg + 10'd1;
        miss_reg    <= miss_reg | ~far_ok;
      end
    end
  end
  wire no_events = ~|interval_event_flags;

  // ****************************************
  // alarm selection
  // ****************************************
  aer_alarm_if alm ();
  assign alm.active = alarm_lvl;
  aer_alarm_sel u_sel (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .alm      (alm)
  );

  // ****************************************
  // alarm routing
  // ****************************************
  // carrier unit has no modem port; dial-out only when not standalone
  wire route_modem_next = alone_lvl & ctrl_reg[`AER_CTRL_RT_MODEM];
  wire route_com_next   = ctrl_reg[`AER_CTRL_RT_COM];
  wire route_dial_next  = ~alone_lvl & ctrl_reg[`AER_CTRL_RT_DIAL];
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      route_modem_out <= 1'b0;
      route_com_out   <= 1'b0;
      route_dial_out  <= 1'b0;
    end else begin
      route_modem_out <= route_modem_next;
      route_com_out   <= route_com_next;
      route_dial_out  <= route_dial_next;
    end
  end

  // ****************************************
  // notification messages
  // ****************************************
  logic warm_pend_reg;
  logic [3:0] lup_sel;
  logic [3:0] ldn_sel;
  assign lup_sel = link_up_p & if_sel;
  assign ldn_sel = link_dn_p & if_sel;
  wire warm_go   = warm_pend_reg & master_notify_enable & gen_en;
  // an alarm message in the same cycle wins, so the notice stays pending until it goes out
  wire warm_sent = warm_go & ~alm.set_pulse & ~alm.clr_pulse;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      warm_pend_reg <= 1'b1;
    end else if (warm_sent) begin
      warm_pend_reg <= 1'b0;
    end
  end

  // ****************************************
  // message selection
  // ****************************************
  logic              msg_valid_next;
  aer_pkg::aer_msg_t msg_type_next;
  logic [7:0]        msg_code_next;
  // one message per cycle; lower-priority coincident notifications are dropped, except the warm start, which stays pending
  always_comb begin
    msg_valid_next = 1'b1;
    msg_type_next  = aer_pkg::AER_MSG_NONE;
    msg_code_next  = 8'h00;
    if (alm.set_pulse) begin
      msg_type_next = aer_pkg::AER_MSG_ALARM_SET;
      msg_code_next = {5'h00, alm.alarm_idx};
    end else if (alm.clr_pulse) begin
      msg_type_next = aer_pkg::AER_MSG_ALARM_CLR;
      msg_code_next = {5'h00, alm.alarm_idx};
    end else if (!master_notify_enable) begin
      msg_valid_next = 1'b0;
    end else if (warm_go) begin
      msg_type_next = aer_pkg::AER_MSG_WARM_START;
    end else if (auth_p && gen_en) begin
      msg_type_next = aer_pkg::AER_MSG_AUTH_FAIL;
    end else if (vendor_p && vendor_en) begin
      msg_type_next = aer_pkg::AER_MSG_VENDOR;
      msg_code_next = vcode_lvl;
    end else if (link_en && |ldn_sel) begin
      msg_type_next = aer_pkg::AER_MSG_LINK_DOWN;
      msg_code_next = {4'h0, ldn_sel};
    end else if (link_en && |lup_sel) begin
      msg_type_next = aer_pkg::AER_MSG_LINK_UP;
      msg_code_next = {4'h0, lup_sel};
    end else begin
      msg_valid_next = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      msg_valid_out   <= 1'b0;
      msg_type_out    <= aer_pkg::AER_MSG_NONE;
      msg_code_out    <= 8'h00;
      msg_cust_id_out <= 16'h0000;
    end else begin
      msg_valid_out   <= msg_valid_next;
      msg_type_out    <= msg_type_next;
      msg_code_out    <= msg_code_next;
      msg_cust_id_out <= cust_id_reg;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  wire [3:0] irq_ev = {bound_p, alm.clr_pulse, alm.set_pulse, auth_p};
  wire [3:0] irq_w1c = (wr_acc & hit_istat) ? pwdata_in[3:0] : 4'h0;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_reg <= 4'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_w1c) | irq_ev;
    end
  end
  assign irq_out = |(irq_stat_reg & irq_mask_reg);

  // ****************************************
  // read mux
  // ****************************************
  wire [31:0] rd_events_w = {25'h0, far_end_interval_full, no_events, interval_event_flags};
  wire [31:0] rd_hist_w   = {11'h0, work_ev_reg, 5'h0, miss_reg, sec_cnt_reg};
  wire [31:0] rd_alarm_w  = {21'h0, alm.busy, alm.alarm_idx, alarm_lvl};
  wire [31:0] rd_notify_w = {31'h0, warm_pend_reg};
  wire [31:0] rd_istat_w  = {28'h0, irq_stat_reg};
  wire [31:0] rd_imask_w  = {28'h0, irq_mask_reg};
  wire [31:0] rd_cust_w   = {16'h0, cust_id_reg};
  wire        rd_setup    = psel_in & ~penable_in & ~pwrite_in;
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (paddr_in == `AER_OFF_EVENTS) begin
      rd_word = rd_events_w;
    end else if (paddr_in == `AER_OFF_HIST) begin
      rd_word = rd_hist_w;
    end else if (hit_ctrl) begin
      rd_word = ctrl_reg;
    end else if (paddr_in == `AER_OFF_ALARM) begin
      rd_word = rd_alarm_w;
    end else if (paddr_in == `AER_OFF_NOTIFY) begin
      rd_word = rd_notify_w;
    end else if (hit_istat) begin
      rd_word = rd_istat_w;
    end else if (hit_imask) begin
      rd_word = rd_imask_w;
    end else if (hit_cust) begin
      rd_word = rd_cust_w;
    end
  end
  // read data is taken in the setup cycle so the access phase needs no wait state;
  // a status bit that sets during the access phase shows on the next read
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_out <= rd_word;
    end
  end
endmodule

// ==== logic/aer_params.svh ====
/*
  register offsets, field positions, reset values and timing counts of the alarm and event reporter.
  assumes a 32-bit apb slave with word-aligned registers.
*/
`ifndef AER_PARAMS_SVH
`define AER_PARAMS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define AER_OFF_EVENTS      12'h000
`define AER_OFF_HIST        12'h004
`define AER_OFF_CTRL        12'h008
`define AER_OFF_ALARM       12'h00c
`define AER_OFF_NOTIFY      12'h010
`define AER_OFF_IRQ_STAT    12'h014
`define AER_OFF_IRQ_MASK    12'h018
`define AER_OFF_CUST_ID     12'h01c
// ****************************************
// field positions
// ****************************************
`define AER_EV_YELLOW       0
`define AER_EV_DTE_LOS      1
`define AER_EV_EXC_ERR      2
`define AER_EV_FRAME_ERR    3
`define AER_EV_BPV          4
`define AER_EV_NONE         5
`define AER_EV_FULL         6
`define AER_CTRL_MASTER     0
`define AER_CTRL_GEN        1
`define AER_CTRL_VENDOR     2
`define AER_CTRL_LINK       3
`define AER_CTRL_CLEAR      4
`define AER_CTRL_RT_MODEM   5
`define AER_CTRL_RT_COM     6
`define AER_CTRL_RT_DIAL    7
`define AER_CTRL_IF_LSB     8
`define AER_NUM_ALARMS      7
`define AER_NUM_IF          4
`define AER_NUM_IRQ         4
// ****************************************
// reset values and timing
// ****************************************
`define AER_CTRL_RESET      32'h0000_0000
`define AER_CUST_ID_RESET   16'h0000
`define AER_SECONDS_PER_INT 10'd900
`define AER_CLK_HZ          100000000
`define AER_TICK_PERIOD_S   1
`endif

// ==== logic/aer_pkg.sv ====
/*
  types shared by the alarm and event reporter files.
  assumes aer_params.svh is compiled alongside.
*/
package aer_pkg;
  typedef enum logic [2:0] {
    AER_MSG_NONE,
    AER_MSG_ALARM_SET,
    AER_MSG_ALARM_CLR,
    AER_MSG_WARM_START,
    AER_MSG_AUTH_FAIL,
    AER_MSG_VENDOR,
    AER_MSG_LINK_DOWN,
    AER_MSG_LINK_UP
  } aer_msg_t;
endpackage

// ==== logic/aer_alarm_if.sv ====
/*
  carries alarm conditions into the priority selector and its result back.
  assumes one clock domain.
*/
`timescale 1ns/100ps
interface aer_alarm_if;
  logic [6:0] active;
  logic       set_pulse;
  logic       clr_pulse;
  logic [2:0] alarm_idx;
  logic       busy;
  modport owner (output active, input set_pulse, input clr_pulse, input alarm_idx, input busy);
  modport sel   (input active, output set_pulse, output clr_pulse, output alarm_idx, output busy);
endinterface

// ==== logic/aer_alarm_sel.sv ====
/*
  alarm priority selector: reports one alarm at a time, clear only when none left.
  assumes alarm condition levels are already synchronised; bit 0 is highest priority.
*/
`timescale 1ns/100ps
module aer_alarm_sel (
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  aer_alarm_if.sel    alm
);
  logic       busy_reg;
  logic [2:0] idx_reg;
  logic [2:0] top_idx;
  logic       any_active;
  logic       cur_gone;

  // lowest index wins, so simultaneous alarms yield the higher priority
  always_comb begin
    top_idx = 3'h0;
    for (int i = 6; i >= 0; i--) begin
      if (alm.active[i]) begin
        top_idx = 3'(i);
      end
    end
  end

  assign any_active = |alm.active;
  assign cur_gone   = ~alm.active[idx_reg];
  // a new alarm is never reported while the held one stays up, whatever its priority
  assign alm.set_pulse = ~busy_reg & any_active;
  // held alarm ends only when every alarm condition has dropped, no timeout
  assign alm.clr_pulse = busy_reg & cur_gone & ~any_active;
  assign alm.alarm_idx = busy_reg ? idx_reg : top_idx;
  assign alm.busy      = busy_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_reg <= 1'b0;
      idx_reg  <= 3'h0;
    end else if (alm.set_pulse) begin
      busy_reg <= 1'b1;
      idx_reg  <= top_idx;
    end else if (alm.clr_pulse) begin
      busy_reg <= 1'b0;
    end
  end
endmodule

// ==== testbench/aer_top_sva.sv ====
/*
  checker for the alarm and event reporter top ports.
  assumes one clock domain and binds onto every aer_top.
*/
`timescale 1ns/100ps
module aer_top_sva (
  input wire logic              clk_in,
  input wire logic              rst_n_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [11:0]       paddr_in,
  input wire logic [6:0]        alarm_cond_in,
  input wire logic              pready_out,
  input wire logic              pslverr_out,
  input wire logic              msg_valid_out,
  input wire aer_pkg::aer_msg_t msg_type_out,
  input wire logic [7:0]        msg_code_out,
  input wire logic [15:0]       msg_cust_id_out
);
  // ****************************************
  // helpers
  // ****************************************
  logic [3:0] calm_reg;
  logic       held_reg;
  wire        set_w = msg_valid_out && msg_type_out == aer_pkg::AER_MSG_ALARM_SET;
  wire        clr_w = msg_valid_out && msg_type_out == aer_pkg::AER_MSG_ALARM_CLR;
  wire        cid_wr_w = psel_in && penable_in && pwrite_in && paddr_in == 12'h01c;
  // calm counter saturates so it never wraps into a false quiet period
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) calm_reg <= 4'h0;
    else if (alarm_cond_in != 7'h00) calm_reg <= 4'h0;
    else if (calm_reg != 4'hf) calm_reg <= calm_reg + 4'h1;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) held_reg <= 1'b0;
    else if (set_w) held_reg <= 1'b1;
    else if (clr_w) held_reg <= 1'b0;
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_clr_after_set: assert property (clr_w |-> held_reg)
    else $error("alarm clear without a reported alarm");
  a_clr_when_quiet: assert property (clr_w |-> calm_reg >= 4'h3)
    else $error("alarm clear while a condition is active");
  a_set_code_range: assert property (set_w |-> msg_code_out < 8'h07)
    else $error("alarm index out of range");
  a_set_has_cause: assert property (set_w |-> calm_reg < 4'hc)
    else $error("alarm set without a recent condition");
  a_link_code_mask: assert property (msg_valid_out && (msg_type_out == aer_pkg::AER_MSG_LINK_UP ||
    msg_type_out == aer_pkg::AER_MSG_LINK_DOWN) |-> msg_code_out[7:4] == 4'h0)
    else $error("link message names an unknown interface");
  a_cust_id_source: assert property ($changed(msg_cust_id_out) |->
    $past(cid_wr_w, 1) || $past(cid_wr_w, 2) || $past(cid_wr_w, 3))
    else $error("customer id changed without a write");
  a_ready_no_wait: assert property (psel_in && penable_in |-> pready_out)
    else $error("apb access phase stalled");
  a_err_in_access: assert property (pslverr_out |-> psel_in && penable_in)
    else $error("slave error outside access phase");
  c_alarm_set: cover property (set_w);
  c_alarm_clr: cover property (clr_w);
  c_warm: cover property (msg_valid_out && msg_type_out == aer_pkg::AER_MSG_WARM_START);
endmodule
bind aer_top aer_top_sva aer_top_sva_inst (.*);

// ==== testbench/aer_msg_sink.sv ====
/*
  far side message receiver standing for a terminal or manager.
  assumes msg_valid is a one cycle pulse on clk_in.
*/
`timescale 1ns/100ps
module aer_msg_sink (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              msg_valid_in,
  input  wire aer_pkg::aer_msg_t msg_type_in,
  input  wire logic [7:0]        msg_code_in,
  input  wire logic [15:0]       msg_cust_id_in,
  output logic      [31:0]       count_out,
  output logic      [31:0]       last_out
);
  // ****************************************
  // capture
  // ****************************************
  // keeps only the newest message; the bench reads it before the next one
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_out <= 32'h0;
      last_out  <= 32'h0;
    end else if (msg_valid_in) begin
      count_out <= count_out + 32'h1;
      last_out  <= {5'h0, msg_type_in, msg_code_in, msg_cust_id_in};
    end
  end
endmodule

// ==== testbench/alarm_event_reporter_test.sv ====
/*
  self checking bench for aer_top with a message sink on the far side.
  assumes aer_pkg, aer_params.svh and the checker are compiled first.
*/
`timescale 1ns/100ps
module alarm_event_reporter_test;
  // ****************************************
  // signals
  // ****************************************
  logic              clk_in = 0, rst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic              sec_tick_in = 0, far_sec_ok_in = 0, interval_end_in = 0, standalone_in = 1;
  logic              auth_fail_in = 0, vendor_event_in = 0, err;
  logic [11:0]       paddr_in = 0;
  logic [31:0]       pwdata_in = 0, rd, seed = 32'h9c04635c, cnt, last, base;
  logic [4:0]        event_in = 0, fl;
  logic [6:0]        alarm_cond_in = 0;
  logic [7:0]        vendor_code_in = 0;
  logic [3:0]        link_state_in = 0;
  logic [15:0]       cid;
  wire  [31:0]       prdata_out;
  wire               pready_out, pslverr_out, msg_valid_out, route_modem_out, route_com_out;
  wire               route_dial_out, irq_out;
  wire  [7:0]        msg_code_out;
  wire  [15:0]       msg_cust_id_out;
  aer_pkg::aer_msg_t msg_type_out;
  int                mismatches = 0, n_tests = 0;
  aer_top aer_top_inst (.*);
  aer_msg_sink aer_msg_sink_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .msg_valid_in(msg_valid_out),
    .msg_type_in(msg_type_out), .msg_code_in(msg_code_out), .msg_cust_id_in(msg_cust_id_out),
    .count_out(cnt), .last_out(last));
  initial forever #5 clk_in = ~clk_in;
  // ****************************************
  // tasks
  // ****************************************
  function logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function logic [31:0] ev_exp(input logic [4:0] f, input logic full);
    return {25'h0, full, f == 5'h0, f};
  endfunction
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_in <= 1; pwrite_in <= w; paddr_in <= a; pwdata_in <= d; penable_in <= 0;
    @(posedge clk_in) penable_in <= 1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) @(posedge clk_in);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0; penable_in <= 0;
    @(posedge clk_in);
  endtask
  task await_msg(input aer_pkg::aer_msg_t t, input logic [7:0] c, input bit cc);
    for (int i = 0; i < 40 && cnt == base; i++) cyc(1);
    chk(cnt, base + 1);
    chk({29'h0, last[26:24]}, {29'h0, t});
    if (cc) chk({24'h0, last[23:16]}, {24'h0, c});
    chk({16'h0, last[15:0]}, {16'h0, cid});
    base = cnt;
  endtask
  task quiet;
    cyc(30);
    chk(cnt, base);
  endtask
  task boundary;
    interval_end_in <= 1; cyc(6); interval_end_in <= 0; cyc(8);
  endtask
  task ticks(input int n, input int miss);
    for (int i = 0; i < n; i++) begin
      far_sec_ok_in <= (i != miss); sec_tick_in <= 1; cyc(6); sec_tick_in <= 0; cyc(6);
    end
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    cyc(60000);
    mismatches++;
    summarize();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    cyc(3);
    rst_n_in <= 1;
    cyc(1);
    for (int k = 0; k < 4; k++) begin
      seed = nxt(seed);
      fl = (k == 0) ? 5'h1f : (k == 3) ? 5'h0 : seed[4:0];
      event_in <= fl; cyc(8); event_in <= 0; cyc(6);
      boundary();
      apb(0, 12'h000, 0); chk(rd, ev_exp(fl, 0));
    end
    $display("test interval flags done");
    ticks(900, -1);
    apb(0, 12'h004, 0); chk(rd, 32'h384);
    boundary();
    apb(0, 12'h000, 0); chk(rd, 32'h60);
    ticks(900, 450);
    apb(0, 12'h004, 0); chk(rd[10], 1'b1);
    boundary();
    apb(0, 12'h000, 0); chk(rd, 32'h20);
    event_in <= 5'h11; cyc(8); event_in <= 0; cyc(6);
    apb(0, 12'h004, 0); chk(rd[20:16], 5'h11);
    apb(1, 12'h008, 32'h10); cyc(2);
    apb(0, 12'h004, 0); chk(rd, 32'h0);
    $display("test far end and clear done");
    seed = nxt(seed); cid = seed[15:0];
    apb(1, 12'h01c, {16'h0, cid});
    apb(1, 12'h014, 32'hf);
    apb(1, 12'h018, 32'h6); base = cnt;
    alarm_cond_in <= 7'b0010100; await_msg(aer_pkg::AER_MSG_ALARM_SET, 8'h2, 1);
    cyc(3); chk(irq_out, 1'b1);
    apb(0, 12'h014, 0); chk(rd, 32'h2);
    apb(1, 12'h014, 32'h2); apb(0, 12'h014, 0); chk(rd, 32'h0);
    chk(irq_out, 1'b0);
    alarm_cond_in <= 7'b0010101; quiet();
    alarm_cond_in <= 7'b0000001; quiet();
    apb(1, 12'h018, 32'h0);
    alarm_cond_in <= 7'b0; await_msg(aer_pkg::AER_MSG_ALARM_CLR, 8'h2, 1);
    cyc(3); apb(0, 12'h014, 0); chk(rd, 32'h4); chk(irq_out, 1'b0);
    apb(1, 12'h014, 32'h4);
    $display("test alarms done");
    apb(1, 12'h008, 32'h60); cyc(2);
    chk({29'h0, route_modem_out, route_com_out, route_dial_out}, 32'h6);
    standalone_in <= 0; apb(1, 12'h008, 32'he0); cyc(6);
    chk({29'h0, route_modem_out, route_com_out, route_dial_out}, 32'h3);
    standalone_in <= 1;
    auth_fail_in <= 1; cyc(8); auth_fail_in <= 0; quiet();
    apb(1, 12'h008, 32'h16f); await_msg(aer_pkg::AER_MSG_WARM_START, 8'h0, 0);
    auth_fail_in <= 1; cyc(8); auth_fail_in <= 0; await_msg(aer_pkg::AER_MSG_AUTH_FAIL, 8'h0, 0);
    seed = nxt(seed); vendor_code_in <= seed[7:0];
    vendor_event_in <= 1; cyc(8); vendor_event_in <= 0;
    await_msg(aer_pkg::AER_MSG_VENDOR, seed[7:0], 1);
    link_state_in <= 4'h1; await_msg(aer_pkg::AER_MSG_LINK_UP, 8'h1, 1);
    link_state_in <= 4'h3; quiet();
    link_state_in <= 4'h2; await_msg(aer_pkg::AER_MSG_LINK_DOWN, 8'h1, 1);
    apb(1, 12'h008, 32'h16b);
    vendor_event_in <= 1; cyc(8); vendor_event_in <= 0; quiet();
    apb(0, 12'hffc, 0); chk(err, 1'b1);
    $display("test notifications done");
    rst_n_in <= 0; cyc(2); rst_n_in <= 1; cyc(2);
    cid = 16'h0; base = 0;
    apb(1, 12'h008, 32'h3); await_msg(aer_pkg::AER_MSG_WARM_START, 8'h0, 0);
    $display("test restart done");
    summarize();
  end
endmodule
